// File: inc/lrsd_defines.vh
// Constants for the legacy region and SMM RAM decode block
`ifndef LRSD_DEFINES_VH
`define LRSD_DEFINES_VH

// ----------------------------------------
// Configuration offsets
// ----------------------------------------
`define LRSD_OFF_ATTR_FIRST 8'h90
`define LRSD_OFF_ATTR_LAST  8'h96
`define LRSD_OFF_HOLE       8'h97
`define LRSD_OFF_SMM        8'h9d
`define LRSD_OFF_ESMM       8'h9e

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define LRSD_HOLE_RST       8'h00
`define LRSD_SMM_RST        8'h02
`define LRSD_ATTR_RST       8'h00
`define LRSD_ESMM_RST       8'h38
`define LRSD_ATTR_MASK      8'h33
`define LRSD_ATTR0_MASK     8'h30
`define LRSD_BASE_SEG       3'b010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LRSD_HOLE_EN_BIT    7
`define LRSD_OPEN_BIT       6
`define LRSD_CLOSED_BIT     5
`define LRSD_LOCK_BIT       4
`define LRSD_GLOBAL_BIT     3
`define LRSD_HIGH_EN_BIT    7
`define LRSD_ERR_BIT        6
`define LRSD_TSZ_HI         2
`define LRSD_TSZ_LO         1
`define LRSD_TOP_EN_BIT     0

// ----------------------------------------
// Address windows (host address bits 31:14)
// ----------------------------------------
`define LRSD_BLK_LOW_END    18'h00020
`define LRSD_BLK_DOS_END    18'h00028
`define LRSD_BLK_VGA_END    18'h00030
`define LRSD_BLK_EXP_END    18'h00038
`define LRSD_BLK_EXT_END    18'h0003c
`define LRSD_BLK_TOP_END    18'h00040
`define LRSD_BLK_HOLE_LO    18'h003c0
`define LRSD_BLK_HOLE_END   18'h00400

// ----------------------------------------
// Targets and initiators
// ----------------------------------------
`define LRSD_TGT_MEM        2'h0
`define LRSD_TGT_PCI        2'h1
`define LRSD_TGT_AGP        2'h2
`define LRSD_TGT_HUB        2'h3
`define LRSD_SRC_HOST       2'h0
`define LRSD_SRC_HUB        2'h1
`define LRSD_SRC_AGP        2'h2

`endif

// File: verification/lrsd_decode_bench.sv
// Self-checking bench for the legacy region and SMM RAM decode block
`timescale 1ns/1ps
`default_nettype none
`include "lrsd_defines.vh"
module lrsd_decode_bench;
  logic        sys_clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, vga_to_agp = 0;
  logic [7:0]  cfg_addr = 0, cfg_wdata = 0, cfg_rdata;
  logic        req_valid, req_write, req_code, req_smm, rsp_valid, rsp_refused, rsp_smm_hit;
  logic        smm_global_en, smm_locked, high_smm_ram_control_active, top_segment_active;
  logic [31:0] req_addr;
  logic [1:0]  req_source, rsp_target, top_segment_size;
  int          err_total = 0, n_compared = 0;
  localparam logic [2:0] mem = {1'b0, `LRSD_TGT_MEM}, pci = {1'b0, `LRSD_TGT_PCI};
  localparam logic [2:0] agp = {1'b0, `LRSD_TGT_AGP}, refd = {1'b1, `LRSD_TGT_MEM};
  always #5 sys_clk = ~sys_clk;
  lrsd_host host (.*);
  lrsd_decode dut (.*);
  task automatic chk(input string n, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    cfg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge sys_clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge sys_clk);
    cfg_rd = 0;
    chk("cfg_rdata", cfg_rdata, exp);
  endtask
  task automatic rq(input logic [31:0] a, input logic [4:0] f, input logic [2:0] e);
    host.issue(a, f);
    chk("response", {4'h0, rsp_valid, rsp_refused, rsp_target}, {4'h0, 1'b1, e});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(8'h97, 8'h00);
    rd(8'h9d, 8'h02);
    rd(8'h50, 8'h00);
    wr(8'h90, 8'hff);
    rd(8'h90, 8'h30);
    for (int i = 1; i < 7; i++)
    begin
      wr(8'h90 + 8'(i), 8'hff);
      rd(8'h90 + 8'(i), 8'h33);
      wr(8'h90 + 8'(i), 8'h00);
    end
    wr(8'h90, 8'h00);
    wr(8'h97, 8'hff);
    rd(8'h97, 8'h80);
    $display("register test done");
  endtask
  task automatic t_dos;
    rq(32'h7fffc, 5'h00, mem);
    rq(32'h80000, 5'h00, pci);
    rq(32'hf00000, 5'h00, pci);
    rq(32'heffffc, 5'h00, mem);
    rq(32'h1000000, 5'h00, mem);
    wr(8'h97, 8'h00);
    rq(32'h9fffc, 5'h00, mem);
    rq(32'hfffffc, 5'h00, mem);
    $display("low area test done");
  endtask
  task automatic t_video;
    rq(32'ha0000, 5'h00, pci);
    vga_to_agp = 1;
    rq(32'hbfffc, 5'h10, agp);
    rq(32'ha0000, 5'h04, agp);
    vga_to_agp = 0;
    $display("video test done");
  endtask
  task automatic t_attr;
    wr(8'h91, 8'h01);
    rq(32'hc0000, 5'h00, mem);
    rq(32'hc0000, 5'h10, pci);
    rq(32'hc4000, 5'h00, pci);
    wr(8'h94, 8'h20);
    rq(32'hdc000, 5'h10, mem);
    wr(8'h96, 8'h10);
    rq(32'hec000, 5'h00, mem);
    rq(32'he8000, 5'h00, pci);
    wr(8'h90, 8'h30);
    rq(32'hf0000, 5'h10, mem);
    rq(32'hffffc, 5'h00, mem);
    $display("attribute test done");
  endtask
  task automatic t_smm;
    wr(8'h9d, 8'h08);
    rq(32'ha0000, 5'h0c, mem);
    chk("smm_hit", {7'h0, rsp_smm_hit}, 8'h01);
    rq(32'ha0000, 5'h00, pci);
    rq(32'ha0000, 5'h01, refd);
    rq(32'ha0000, 5'h02, refd);
    wr(8'h9d, 8'h28);
    rq(32'ha0000, 5'h04, pci);
    rq(32'ha0000, 5'h0c, mem);
    wr(8'h9d, 8'h48);
    rq(32'ha0000, 5'h00, mem);
    wr(8'h9d, 8'h40);
    rq(32'ha0000, 5'h00, pci);
    $display("smm test done");
  endtask
  task automatic t_lock;
    wr(8'h9e, 8'h85);
    chk("extended", {6'h0, high_smm_ram_control_active, top_segment_active}, 8'h00);
    wr(8'h9d, 8'h48);
    chk("extended", {6'h0, high_smm_ram_control_active, top_segment_active}, 8'h03);
    // Open cleared before lock is set
    wr(8'h9d, 8'h08);
    wr(8'h9d, 8'h18);
    wr(8'h9d, 8'h60);
    rd(8'h9d, 8'h3a);
    chk("lock", {6'h0, smm_global_en, smm_locked}, 8'h03);
    wr(8'h9e, 8'h00);
    rd(8'h9e, 8'hbd);
    chk("top_segment_size", {6'h0, top_segment_size}, 8'h02);
    rq(32'ha0000, 5'h00, pci);
    @(negedge sys_clk);
    rst = 1;
    repeat (2) @(negedge sys_clk);
    rst = 0;
    rd(8'h9d, 8'h02);
    $display("lock test done");
  endtask
  task automatic t_order;
    fork
      wr(8'h97, 8'h80);
      rq(32'h80000, 5'h00, mem);
    join
    rq(32'h80000, 5'h00, pci);
    $display("order test done");
  endtask
  task automatic test_done;
    $display("compared %0d wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge sys_clk);
    rst = 0;
    t_regs();
    t_dos();
    t_video();
    t_attr();
    t_smm();
    t_lock();
    t_order();
    test_done();
  end
  initial
  begin
    #20000;
    err_total++;
    test_done();
  end
endmodule // lrsd_decode_bench
`default_nettype wire

// File: verification/lrsd_decode_monitor.sv
// Checker for the legacy region and SMM RAM decode block
`timescale 1ns/1ps
`default_nettype none
module lrsd_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [7:0]  cfg_rdata,
  input wire logic        req_valid,
  input wire logic [31:0] req_addr,
  input wire logic        req_code,
  input wire logic        req_smm,
  input wire logic [1:0]  req_source,
  input wire logic        vga_to_agp,
  input wire logic        rsp_valid,
  input wire logic [1:0]  rsp_target,
  input wire logic        rsp_refused,
  input wire logic        rsp_smm_hit,
  input wire logic        smm_global_en,
  input wire logic        smm_locked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Request inside the video buffer range
  wire vid = req_valid && req_addr[31:17] == 15'h0005;
  wire host = req_source == 2'h0;

  a_resp_one_cycle: assert property (req_valid |=> rsp_valid)
    else $error("response missing one cycle after request");
  a_low_to_mem: assert property (req_valid && req_addr < 32'h80000 |=> rsp_target == 2'h0)
    else $error("low 512 KB not sent to memory");
  a_video_route: assert property (vid && host && !smm_global_en
    |=> rsp_target == ($past(vga_to_agp) ? 2'h2 : 2'h1))
    else $error("video range routed wrongly");
  a_smm_refuse: assert property (vid && !host && smm_global_en |=> rsp_refused)
    else $error("downstream access to SMM range not refused");
  a_smm_code: assert property (vid && host && req_smm && req_code && smm_global_en
    |=> rsp_smm_hit && rsp_target == 2'h0)
    else $error("SMM code fetch not claimed");
  a_lock_sticky: assert property (smm_locked |=> smm_locked)
    else $error("lock cleared without reset");
  a_global_frozen: assert property (smm_locked |=> $stable(smm_global_en))
    else $error("global enable changed after lock");
  a_base_seg: assert property (cfg_rd && cfg_addr == 8'h9d
    |=> !cfg_rdata[7] && cfg_rdata[2:0] == 3'b010)
    else $error("SMM control fixed bits wrong");
  a_hole_rsvd: assert property (cfg_rd && cfg_addr == 8'h97 |=> cfg_rdata[6:0] == 7'h00)
    else $error("hole register reserved bits not zero");

  c_smm_hit: cover property (vid && req_smm && smm_global_en);
  c_refused: cover property (rsp_refused);
  c_locked: cover property ($rose(smm_locked));
endmodule // lrsd_chk

bind lrsd_decode lrsd_chk u_chk (.*);
`default_nettype wire

// File: verification/lrsd_host_model.sv
// Host bus model issuing one decode request per call
`timescale 1ns/1ps
`default_nettype none
module lrsd_host (
  input  wire logic   sys_clk,
  output logic        req_valid,
  output logic [31:0] req_addr,
  output logic        req_write,
  output logic        req_code,
  output logic        req_smm,
  output logic [1:0]  req_source
);
  initial {req_valid, req_addr, req_write, req_code, req_smm, req_source} = '0;
  // Flags are write, code, smm, then source
  task automatic issue(input logic [31:0] a, input logic [4:0] f);
    @(negedge sys_clk);
    {req_valid, req_addr, req_write, req_code, req_smm, req_source} = {1'b1, a, f};
    @(negedge sys_clk);
    req_valid = 1'b0;
    // Released address stops showing the last value
    req_addr = ~a;
  endtask
endmodule // lrsd_host
`default_nettype wire

// File: verilog/lrsd_decode.v
// Legacy region, fixed hole and compatible SMM RAM decode
// Notes on behaviour
// - Lowest 512 KB always goes to memory
// - 512-640 KB memory, or hole to PCI
// - Video range ignores attributes, goes downstream
// - VGA control picks PCI or AGP
// - SMM video range refused from hub/AGP
// - Expansion range: eight 16 KB segments
// - Extended firmware: four 16 KB segments
// - Firmware range: one 64 KB segment
// - Hole enable blocks 15-16 MB memory
// - Open and closed need global enable, lock does not
// - Open and unlocked exposes SMM memory
// - Closed sends SMM data downstream, allows code fetches
// - Lock clears open, freezes global enable and extended fields
// - Lock set by write, cleared by reset
// - Global enable gives 128 KB SMM
// - Extended SMM_RAM_CONTROL only with global enable
// - Global enable read-only after lock
// - Base segment hardwired to video pattern
// - SMM not remapped, else to PCI or AGP
// - Attribute read/write enables route memory
// - Seven attribute registers at consecutive offsets
`timescale 1ns/1ps
`default_nettype none
`include "lrsd_defines.vh"

module lrsd_decode (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [7:0]  cfg_addr,
  input  wire [7:0]  cfg_wdata,
  output reg  [7:0]  cfg_rdata,
  input  wire        req_valid,
  input  wire [31:0] req_addr,
  input  wire        req_write,
  input  wire        req_code,
  input  wire        req_smm,
  input  wire [1:0]  req_source,
  input  wire        vga_to_agp,
  output reg         rsp_valid,
  output reg  [1:0]  rsp_target,
  output reg         rsp_refused,
  output reg         rsp_smm_hit,
  output wire        smm_global_en,
  output wire        smm_locked,
  output wire        high_smm_ram_control_active,
  output wire        top_segment_active,
  output wire [1:0]  top_segment_size
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0] attr_reg [0:6];
  reg       hole_enable_reg;
  reg       smm_open_reg;
  reg       smm_closed_reg;
  reg       smm_lock_reg;
  reg       global_smm_ram_control_enable_reg;
  reg       high_smm_ram_control_enable_reg;
  reg [1:0] top_segment_size_reg;
  reg       top_segment_enable_reg;

  wire [17:0] blk = req_addr[31:14];
  wire        smm_wr = cfg_wr && (cfg_addr == `LRSD_OFF_SMM);
  wire        esmm_wr = cfg_wr && (cfg_addr == `LRSD_OFF_ESMM);

  // Attribute register index from a segment block number
  function [2:0] attr_index;
    input [17:0] b;
    begin
      // Blocks outside the segmented range fall back to register 0
      if (b >= `LRSD_BLK_EXT_END || b < `LRSD_BLK_VGA_END)
        attr_index = 3'h0;
      else
        // Two 16 KB blocks per register, first segment register is 1
        attr_index = 3'h1 + b[3:1];
    end
  endfunction

  // Attribute nibble for a block: read-enable and write-enable bits
  function [1:0] seg_attr;
    input [17:0] b;
    input [7:0]  r;
    begin
      if (b >= `LRSD_BLK_EXT_END)
        seg_attr = r[5:4];
      else if (b[0])
        seg_attr = r[5:4];
      else
        seg_attr = r[1:0];
    end
  endfunction

  // ----------------------------------------
  // Configuration writes
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_attr
      always @(posedge sys_clk)
      begin
        if (rst)
          attr_reg[gi] <= `LRSD_ATTR_RST;
        else if (cfg_wr && (cfg_addr == `LRSD_OFF_ATTR_FIRST + gi[7:0]))
          // low half of register 0 is reserved
          attr_reg[gi] <= cfg_wdata & ((gi == 0) ? `LRSD_ATTR0_MASK : `LRSD_ATTR_MASK);
      end
    end
  endgenerate

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      hole_enable_reg         <= 1'b0;
      smm_open_reg            <= 1'b0;
      smm_closed_reg          <= 1'b0;
      smm_lock_reg            <= 1'b0;
      global_smm_ram_control_enable_reg <= 1'b0;
      high_smm_ram_control_enable_reg   <= 1'b0;
      top_segment_size_reg    <= 2'h0;
      top_segment_enable_reg  <= 1'b0;
    end
    else
    begin
      if (cfg_wr && (cfg_addr == `LRSD_OFF_HOLE))
        hole_enable_reg <= cfg_wdata[`LRSD_HOLE_EN_BIT];
      if (smm_wr)
      begin
        smm_closed_reg <= cfg_wdata[`LRSD_CLOSED_BIT];
        if (!smm_lock_reg)
          global_smm_ram_control_enable_reg <= cfg_wdata[`LRSD_GLOBAL_BIT];
        if (cfg_wdata[`LRSD_LOCK_BIT])
          smm_lock_reg <= 1'b1;
        if (smm_lock_reg || cfg_wdata[`LRSD_LOCK_BIT])
          smm_open_reg <= 1'b0;
        else
          smm_open_reg <= cfg_wdata[`LRSD_OPEN_BIT];
      end
      if (esmm_wr && !smm_lock_reg)
      begin
        high_smm_ram_control_enable_reg  <= cfg_wdata[`LRSD_HIGH_EN_BIT];
        top_segment_size_reg   <= cfg_wdata[`LRSD_TSZ_HI:`LRSD_TSZ_LO];
        top_segment_enable_reg <= cfg_wdata[`LRSD_TOP_EN_BIT];
      end
    end
  end

  // ----------------------------------------
  // Configuration reads
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst)
      cfg_rdata <= 8'h00;
    else if (cfg_rd)
    begin
      if (cfg_addr >= `LRSD_OFF_ATTR_FIRST && cfg_addr <= `LRSD_OFF_ATTR_LAST)
        cfg_rdata <= attr_reg[cfg_addr[2:0]];
      else if (cfg_addr == `LRSD_OFF_HOLE)
        cfg_rdata <= {hole_enable_reg, 7'h00};
      else if (cfg_addr == `LRSD_OFF_SMM)
        cfg_rdata <= {1'b0, smm_open_reg, smm_closed_reg, smm_lock_reg,
                      global_smm_ram_control_enable_reg, `LRSD_BASE_SEG};
      else if (cfg_addr == `LRSD_OFF_ESMM)
        cfg_rdata <= {high_smm_ram_control_enable_reg, 4'h7, top_segment_size_reg,
                      top_segment_enable_reg};
      else
        cfg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // SMM qualifiers
  // ----------------------------------------
  // controls gated by global enable
  wire eff_open   = global_smm_ram_control_enable_reg && smm_open_reg && !smm_lock_reg;
  wire eff_closed = global_smm_ram_control_enable_reg && smm_closed_reg;

  assign smm_global_en      = global_smm_ram_control_enable_reg;
  assign smm_locked         = smm_lock_reg;
  assign high_smm_ram_control_active  = global_smm_ram_control_enable_reg && high_smm_ram_control_enable_reg;
  assign top_segment_active = global_smm_ram_control_enable_reg && top_segment_enable_reg;
  assign top_segment_size   = top_segment_size_reg;

  // ----------------------------------------
  // Region decode
  // ----------------------------------------
  reg [1:0] tgt_next;
  reg       ref_next;
  reg       hit_next;
  reg [1:0] attr_bits;
  reg       smm_ok;

  always @*
  begin
    tgt_next  = `LRSD_TGT_MEM;
    ref_next  = 1'b0;
    hit_next  = 1'b0;
    attr_bits = seg_attr(blk, attr_reg[attr_index(blk)]);
    smm_ok    = global_smm_ram_control_enable_reg &&
                ((req_smm && (req_code || !eff_closed)) || eff_open);
    if (req_source != `LRSD_SRC_HOST)
    begin
      // Downstream initiators are refused in SMM video range
      // no hub/AGP access to SMM
      if (blk >= `LRSD_BLK_DOS_END && blk < `LRSD_BLK_VGA_END &&
          global_smm_ram_control_enable_reg)
        ref_next = 1'b1;
    end
    else if (blk < `LRSD_BLK_LOW_END)
      tgt_next = `LRSD_TGT_MEM;
    else if (blk < `LRSD_BLK_DOS_END)
      tgt_next = hole_enable_reg ? `LRSD_TGT_PCI : `LRSD_TGT_MEM;
    else if (blk < `LRSD_BLK_VGA_END)
    begin
      if (smm_ok)
      begin
        tgt_next = `LRSD_TGT_MEM;
        hit_next = 1'b1;
      end
      else
        tgt_next = vga_to_agp ? `LRSD_TGT_AGP : `LRSD_TGT_PCI;
    end
    else if (blk < `LRSD_BLK_TOP_END)
    begin
      if (req_write ? attr_bits[1] : attr_bits[0])
        tgt_next = `LRSD_TGT_MEM;
      else
        tgt_next = `LRSD_TGT_PCI;
    end
    else if (blk >= `LRSD_BLK_HOLE_LO && blk < `LRSD_BLK_HOLE_END &&
             hole_enable_reg)
      tgt_next = `LRSD_TGT_PCI;
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      rsp_valid   <= 1'b0;
      rsp_target  <= `LRSD_TGT_MEM;
      rsp_refused <= 1'b0;
      rsp_smm_hit <= 1'b0;
    end
    else
    begin
      rsp_valid <= req_valid;
      if (req_valid)
      begin
        rsp_target  <= tgt_next;
        rsp_refused <= ref_next;
        rsp_smm_hit <= hit_next;
      end
    end
  end

endmodule // lrsd_decode
`default_nettype wire
